// *** rtl/ssq_clkmon.sv ***
// Edge finder and period meter for the clock on the shared clock pin.
`timescale 1ns/100ps
module ssq_clkmon (
	// Clock and reset.
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	// Raw pin level.
	input  wire logic                       pin_i,
	// Measurement.
	output logic                            edge_o,
	output logic                            present_o,
	output logic [ssq_pkg::PER_W-1:0]       period_o
);

	localparam logic [ssq_pkg::PER_W:0] LOSS =
		(ssq_pkg::PER_W+1)'(ssq_pkg::EXT_LOSS_CYC);
	localparam logic [ssq_pkg::PER_W:0] PMIN =
		(ssq_pkg::PER_W+1)'(ssq_pkg::EXT_MIN_CYC);
	localparam logic [ssq_pkg::PER_W:0] PMAX =
		(ssq_pkg::PER_W+1)'(ssq_pkg::EXT_MAX_CYC);

	logic                   s1_q;
	logic                   s2_q;
	logic                   s3_q;
	logic [ssq_pkg::PER_W:0] cnt_q;

	wire rise   = s2_q & ~s3_q;
	wire in_rng = (cnt_q + 1'b1 >= PMIN) && (cnt_q + 1'b1 <= PMAX);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_q      <= 1'b0;
			s2_q      <= 1'b0;
			s3_q      <= 1'b0;
			cnt_q     <= '0;
			edge_o    <= 1'b0;
			present_o <= 1'b0;
			period_o  <= '0;
		end else begin
			s1_q   <= pin_i;
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			edge_o <= rise;
			if (rise) begin
				cnt_q     <= '0;
				present_o <= in_rng;
				if (in_rng) begin
					period_o <= ssq_pkg::PER_W'(cnt_q + 1'b1);
				end
			end else if (cnt_q >= LOSS) begin
				present_o <= 1'b0;
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

endmodule : ssq_clkmon

// *** rtl/ssq_pkg.sv ***
// Shared constants, types and register map of the start-up sequencer.
package ssq_pkg;

	// Clock and time base.
	localparam int CLK_PERIOD_PS = 5000;
	localparam int CLK_HZ        = 1000000000 / (CLK_PERIOD_PS / 1000);
	localparam int US_NS         = 1000;
	localparam int US_CYC        = (US_NS * 1000) / CLK_PERIOD_PS;
	localparam int US_PER_MS     = 1000;
	localparam int INIT_MS       = 5;
	localparam int MIN_DLY_MS    = 2;

	// Switching frequencies of the internal oscillator.
	localparam int F_LOW_HZ      = 200000;
	localparam int F_MID_HZ      = 400000;
	localparam int F_HIGH_HZ     = 1000000;
	localparam int OSC_LOW_CYC   = CLK_HZ / F_LOW_HZ;
	localparam int OSC_MID_CYC   = CLK_HZ / F_MID_HZ;
	localparam int OSC_HIGH_CYC  = CLK_HZ / F_HIGH_HZ;

	// Accepted range of an incoming clock on the shared clock pin.
	localparam int EXT_MIN_HZ    = 200000;
	localparam int EXT_MAX_HZ    = 1400000;
	localparam int EXT_MAX_CYC   = CLK_HZ / EXT_MIN_HZ;
	localparam int EXT_MIN_CYC   = CLK_HZ / EXT_MAX_HZ;
	localparam int EXT_LOSS_CYC  = 2 * EXT_MAX_CYC;
	localparam int PER_W         = 11;

	// Strap decoding.
	localparam int N_STRAP       = 5;
	localparam int PIN_RAMP      = 0;
	localparam int PIN_DLYL      = 1;
	localparam int PIN_DLYH      = 2;
	localparam int PIN_CFG       = 3;
	localparam int PIN_SYNC      = 4;
	localparam int N_RES         = 2;
	localparam int RES_RAMP      = 0;
	localparam int RES_DLY       = 1;
	localparam int RES_STEP_MS   = 10;
	localparam int RES_MAX_CODE  = 20;
	localparam logic [15:0] DLY_TAB [9] = '{16'h0000, 16'h0001, 16'h0002,
		16'h0005, 16'h000A, 16'h0014, 16'h0032, 16'h0064, 16'h00C8};
	localparam logic [15:0] RAMP_TAB [3] = '{16'h0000, 16'h0005, 16'h000A};

	// Ramp reference full scale.
	localparam logic [9:0] RAMP_FULL = 10'h3FF;

	// Register offsets.
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_DLY    = 8'h04;
	localparam logic [7:0] REG_RAMP   = 8'h08;
	localparam logic [7:0] REG_PGDLY  = 8'h0C;
	localparam logic [7:0] REG_PGWIN  = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_STRAP  = 8'h18;

	// Control fields and reset values.
	localparam int CTRL_RESTORE = 0;
	localparam int CTRL_SW_DLY  = 1;
	localparam int CTRL_SW_RAMP = 2;
	localparam int CTRL_SW_PGD  = 3;
	localparam int CTRL_PG_POL  = 4;
	localparam logic [31:0] CTRL_RST  = 32'h0000_0010;
	localparam logic [31:0] PGWIN_RST = 32'h0000_0F0A;
	localparam logic [31:0] TIME_RST  = 32'h0000_0000;

	typedef enum logic [1:0] {
		LVL_LOW  = 2'b00,
		LVL_OPEN = 2'b01,
		LVL_HIGH = 2'b10
	} ssq_lvl_t;

	typedef enum logic [2:0] {
		ST_INIT   = 3'b000,
		ST_SAMPLE = 3'b001,
		ST_READY  = 3'b010,
		ST_DELAY  = 3'b011,
		ST_RAMP   = 3'b100,
		ST_ON     = 3'b101
	} ssq_state_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} ssq_wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} ssq_wb_rsp_t;

	typedef struct packed {
		logic hi;
		logic lo;
	} ssq_cmp_t;

endpackage : ssq_pkg

// *** rtl/ssq_strap.sv ***
// Three-level strap classifier and strap resistor code capture.
`timescale 1ns/100ps
module ssq_strap #(
	parameter int N = 5,
	parameter int R = 2
) (
	// Clock and reset.
	input  wire logic                           clk_i,
	input  wire logic                           rst_i,
	// Comparator pairs and resistor measurement, asynchronous.
	input  wire ssq_pkg::ssq_cmp_t [N-1:0]      cmp_i,
	input  wire logic [R-1:0]                   res_valid_i,
	input  wire logic [R-1:0][4:0]              res_code_i,
	// Capture strobe.
	input  wire logic                           sample_i,
	// Held results.
	output ssq_pkg::ssq_lvl_t [N-1:0]           lvl_o,
	output logic [R-1:0]                        res_hit_o,
	output logic [R-1:0][4:0]                   res_code_o
);

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_pin
			ssq_pkg::ssq_cmp_t s1_q;
			ssq_pkg::ssq_cmp_t s2_q;
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					s1_q     <= '0;
					s2_q     <= '0;
					lvl_o[g] <= ssq_pkg::LVL_OPEN;
				end else begin
					s1_q <= cmp_i[g];
					s2_q <= s1_q;
					if (sample_i) begin
						lvl_o[g] <= s2_q.hi ? ssq_pkg::LVL_HIGH :
							(s2_q.lo ? ssq_pkg::LVL_LOW : ssq_pkg::LVL_OPEN);
					end
				end
			end
		end
		for (g = 0; g < R; g++) begin : g_res
			logic [5:0] s1_q;
			logic [5:0] s2_q;
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					s1_q          <= '0;
					s2_q          <= '0;
					res_hit_o[g]  <= 1'b0;
					res_code_o[g] <= '0;
				end else begin
					s1_q <= {res_valid_i[g], res_code_i[g]};
					s2_q <= s1_q;
					if (sample_i) begin
						res_hit_o[g]  <= s2_q[5];
						res_code_o[g] <= s2_q[4:0];
					end
				end
			end
		end
	endgenerate

endmodule : ssq_strap

// *** rtl/ssq_top.sv ***
// Start-up sequencer, output-good logic and switching clock selection.
//
// The register addresses and the Wishbone interface to the registers were decided locally.
`timescale 1ns/100ps
module ssq_top #(
	parameter int US_PER_MS  = ssq_pkg::US_PER_MS,
	parameter int INIT_MS    = ssq_pkg::INIT_MS,
	parameter int MIN_DLY_MS = ssq_pkg::MIN_DLY_MS
) (
	// Clock and reset.
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	// Wishbone slave.
	input  wire ssq_pkg::ssq_wb_req_t       wb_req_i,
	output ssq_pkg::ssq_wb_rsp_t            wb_rsp_o,
	// Strap comparators and resistor measurement.
	input  wire ssq_pkg::ssq_cmp_t [ssq_pkg::N_STRAP-1:0] strap_cmp_i,
	input  wire logic [ssq_pkg::N_RES-1:0]  strap_res_valid_i,
	input  wire logic [ssq_pkg::N_RES-1:0][4:0] strap_res_code_i,
	// Enable pin and output monitor.
	input  wire logic                       enable_i,
	input  wire logic [7:0]                 vout_err_i,
	input  wire logic                       fault_i,
	// Shared clock pin.
	input  wire logic                       sync_i,
	output logic                            sync_o,
	output logic                            sync_oe_n_o,
	// Sequencer outputs.
	output logic [9:0]                      ramp_ref_o,
	output logic                            output_good_o,
	output logic                            sw_clk_o,
	output logic                            dev_ready_o
);

	localparam logic [7:0] US_LAST = 8'(ssq_pkg::US_CYC - 1);
	localparam logic [9:0] MS_LAST = 10'(US_PER_MS - 1);
	localparam logic [15:0] MIN_DLY = 16'(MIN_DLY_MS);
	localparam logic [15:0] INIT_T  = 16'(INIT_MS);
	localparam int PW = ssq_pkg::PER_W;

	// Register file.
	logic [31:0] ctrl_q;
	logic [31:0] dly_q;
	logic [31:0] ramp_q;
	logic [31:0] pgd_q;
	logic [31:0] win_q;
	logic        ack_q;
	logic        restore_q;

	wire wb_act = wb_req_i.cyc & wb_req_i.stb;
	wire wb_wr  = wb_act & wb_req_i.we & ack_q;
	wire [31:0] wmask = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}},
		{8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};
	wire [31:0] wdat = wb_req_i.dat & wmask;
	wire hit_ctrl  = wb_req_i.adr == ssq_pkg::REG_CTRL;
	wire hit_dly   = wb_req_i.adr == ssq_pkg::REG_DLY;
	wire hit_ramp  = wb_req_i.adr == ssq_pkg::REG_RAMP;
	wire hit_pgd   = wb_req_i.adr == ssq_pkg::REG_PGDLY;
	wire hit_win   = wb_req_i.adr == ssq_pkg::REG_PGWIN;
	wire hit_stat  = wb_req_i.adr == ssq_pkg::REG_STATUS;
	wire hit_strap = wb_req_i.adr == ssq_pkg::REG_STRAP;

	// Straps and clock monitor.
	ssq_pkg::ssq_lvl_t [ssq_pkg::N_STRAP-1:0] lvl;
	logic [ssq_pkg::N_RES-1:0]      res_hit;
	logic [ssq_pkg::N_RES-1:0][4:0] res_code;
	logic                           ext_edge;
	logic                           ext_present;
	logic [PW-1:0]                  ext_period;

	ssq_pkg::ssq_state_t st_q;
	ssq_pkg::ssq_state_t st_d;

	wire sample = st_q == ssq_pkg::ST_SAMPLE;

	ssq_strap #(
		.N (ssq_pkg::N_STRAP),
		.R (ssq_pkg::N_RES)
	) u_strap (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.cmp_i       (strap_cmp_i),
		.res_valid_i (strap_res_valid_i),
		.res_code_i  (strap_res_code_i),
		.sample_i    (sample),
		.lvl_o       (lvl),
		.res_hit_o   (res_hit),
		.res_code_o  (res_code)
	);

	ssq_clkmon u_clkmon (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.pin_i     (sync_i),
		.edge_o    (ext_edge),
		.present_o (ext_present),
		.period_o  (ext_period)
	);

	// Time selection from straps and software.
	wire [3:0] dly_idx = 4'(3 * int'(lvl[ssq_pkg::PIN_DLYH])
		+ int'(lvl[ssq_pkg::PIN_DLYL]));
	wire [4:0] dcode = (res_code[ssq_pkg::RES_DLY] > 5'(ssq_pkg::RES_MAX_CODE))
		? 5'(ssq_pkg::RES_MAX_CODE) : res_code[ssq_pkg::RES_DLY];
	wire [4:0] rcode = (res_code[ssq_pkg::RES_RAMP] > 5'(ssq_pkg::RES_MAX_CODE))
		? 5'(ssq_pkg::RES_MAX_CODE) : res_code[ssq_pkg::RES_RAMP];
	wire [15:0] strap_dly = res_hit[ssq_pkg::RES_DLY]
		? 16'(int'(dcode) * ssq_pkg::RES_STEP_MS)
		: ssq_pkg::DLY_TAB[dly_idx];
	wire [15:0] strap_ramp = res_hit[ssq_pkg::RES_RAMP]
		? 16'(int'(rcode) * ssq_pkg::RES_STEP_MS)
		: ssq_pkg::RAMP_TAB[int'(lvl[ssq_pkg::PIN_RAMP])];
	wire [15:0] sel_dly = ctrl_q[ssq_pkg::CTRL_SW_DLY] ? dly_q[15:0]
		: strap_dly;
	wire [15:0] eff_dly = (sel_dly < MIN_DLY) ? MIN_DLY : sel_dly;
	wire [15:0] eff_ramp = ctrl_q[ssq_pkg::CTRL_SW_RAMP] ? ramp_q[15:0]
		: strap_ramp;
	wire [15:0] eff_pgd = ctrl_q[ssq_pkg::CTRL_SW_PGD] ? pgd_q[15:0]
		: eff_ramp;
	wire [39:0] ramp_cyc = 40'(eff_ramp) * 40'(US_PER_MS)
		* 40'(ssq_pkg::US_CYC);

	// Enable pin synchroniser.
	logic en_s1_q;
	logic en_s2_q;
	logic en_s3_q;
	wire  en_rise = en_s2_q & ~en_s3_q;

	// Microsecond and millisecond time base, restarted on state change.
	logic [7:0]  us_cnt_q;
	logic [9:0]  ms_cnt_q;
	logic [15:0] tmr_q;
	wire us_tick = us_cnt_q == US_LAST;
	wire ms_tick = us_tick && (ms_cnt_q == MS_LAST);
	wire st_chg  = st_d != st_q;

	// Ramp generator state.
	logic [9:0]  ref_q;
	logic [40:0] acc_q;
	wire  [40:0] acc_add = acc_q + 41'(ssq_pkg::RAMP_FULL);
	wire         acc_ovf = acc_add >= 41'(ramp_cyc);

	// Sequencer transitions.
	always_comb begin
		st_d = st_q;
		case (st_q)
			ssq_pkg::ST_INIT: begin
				if (tmr_q >= INIT_T) begin
					st_d = ssq_pkg::ST_SAMPLE;
				end
			end
			ssq_pkg::ST_SAMPLE: begin
				st_d = ssq_pkg::ST_READY;
			end
			ssq_pkg::ST_READY: begin
				if (en_s2_q) begin
					st_d = ssq_pkg::ST_DELAY;
				end
			end
			ssq_pkg::ST_DELAY: begin
				if (!en_s2_q) begin
					st_d = ssq_pkg::ST_READY;
				end else if (tmr_q >= eff_dly) begin
					st_d = ssq_pkg::ST_RAMP;
				end
			end
			ssq_pkg::ST_RAMP: begin
				if (!en_s2_q) begin
					st_d = ssq_pkg::ST_READY;
				end else if (ref_q == ssq_pkg::RAMP_FULL) begin
					st_d = ssq_pkg::ST_ON;
				end
			end
			ssq_pkg::ST_ON: begin
				if (!en_s2_q) begin
					st_d = ssq_pkg::ST_READY;
				end
			end
			default: begin
				st_d = ssq_pkg::ST_INIT;
			end
		endcase
		if (restore_q) begin
			st_d = ssq_pkg::ST_INIT;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q     <= ssq_pkg::ST_INIT;
			en_s1_q  <= 1'b0;
			en_s2_q  <= 1'b0;
			en_s3_q  <= 1'b0;
			us_cnt_q <= '0;
			ms_cnt_q <= '0;
			tmr_q    <= '0;
		end else begin
			st_q    <= st_d;
			en_s1_q <= enable_i;
			en_s2_q <= en_s1_q;
			en_s3_q <= en_s2_q;
			if (st_chg) begin
				us_cnt_q <= '0;
				ms_cnt_q <= '0;
				tmr_q    <= '0;
			end else begin
				us_cnt_q <= us_tick ? 8'h00 : us_cnt_q + 8'h01;
				if (us_tick) begin
					ms_cnt_q <= (ms_cnt_q == MS_LAST) ? 10'h000
						: ms_cnt_q + 10'h001;
				end
				if (ms_tick && tmr_q != 16'hFFFF) begin
					tmr_q <= tmr_q + 16'h0001;
				end
			end
		end
	end

	// Ramp reference: evenly spaced steps over the ramp time.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ref_q <= '0;
			acc_q <= '0;
		end else if (st_q != ssq_pkg::ST_RAMP && st_q != ssq_pkg::ST_ON) begin
			ref_q <= '0;
			acc_q <= '0;
		end else if (st_q == ssq_pkg::ST_ON) begin
			ref_q <= ssq_pkg::RAMP_FULL;
		end else if (eff_ramp == 16'h0000) begin
			ref_q <= ssq_pkg::RAMP_FULL;
		end else if (ref_q != ssq_pkg::RAMP_FULL) begin
			acc_q <= acc_ovf ? acc_add - 41'(ramp_cyc) : acc_add;
			if (acc_ovf) begin
				ref_q <= ref_q + 10'h001;
			end
		end
	end

	// Output-good window, hold-off and polarity.
	logic [15:0] pgc_q;
	logic        pg_q;
	wire signed [9:0] err_s = {{2{vout_err_i[7]}}, vout_err_i};
	wire signed [9:0] lo_s  = -$signed({2'b00, win_q[7:0]});
	wire signed [9:0] hi_s  = $signed({2'b00, win_q[15:8]});
	wire pg_cond = (st_q == ssq_pkg::ST_ON) && !fault_i
		&& (err_s >= lo_s) && (err_s <= hi_s);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pgc_q <= '0;
			pg_q  <= 1'b0;
		end else if (!pg_cond) begin
			pgc_q <= '0;
			pg_q  <= 1'b0;
		end else if (pgc_q >= eff_pgd) begin
			pg_q <= 1'b1;
		end else if (ms_tick) begin
			pgc_q <= pgc_q + 16'h0001;
		end
	end

	// Switching clock source selection.
	logic          lock_q;
	logic [PW-1:0] hold_per_q;
	logic          hold_q;
	logic [PW-1:0] ph_q;
	wire mode_out  = lvl[ssq_pkg::PIN_CFG] == ssq_pkg::LVL_HIGH;
	wire mode_auto = lvl[ssq_pkg::PIN_CFG] == ssq_pkg::LVL_OPEN;
	wire ready_st  = (st_q != ssq_pkg::ST_INIT) && (st_q != ssq_pkg::ST_SAMPLE);
	wire [PW-1:0] auto_per =
		(lvl[ssq_pkg::PIN_SYNC] == ssq_pkg::LVL_LOW) ? PW'(ssq_pkg::OSC_LOW_CYC) :
		(lvl[ssq_pkg::PIN_SYNC] == ssq_pkg::LVL_HIGH) ? PW'(ssq_pkg::OSC_HIGH_CYC)
		: PW'(ssq_pkg::OSC_MID_CYC);
	wire [PW-1:0] osc_per = lock_q ? ext_period
		: hold_q ? hold_per_q
		: (mode_auto ? auto_per : PW'(ssq_pkg::OSC_MID_CYC));
	wire ph_wrap = ph_q >= osc_per - 1'b1;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lock_q     <= 1'b0;
			hold_q     <= 1'b0;
			hold_per_q <= '0;
			ph_q       <= '0;
			sw_clk_o   <= 1'b0;
		end else begin
			if (st_q == ssq_pkg::ST_READY && en_rise) begin
				lock_q <= !mode_out && ext_present;
				hold_q <= 1'b0;
			end else if (lock_q && !ext_present) begin
				lock_q     <= 1'b0;
				hold_q     <= 1'b1;
				hold_per_q <= ext_period;
			end else if (!ready_st) begin
				lock_q <= 1'b0;
				hold_q <= 1'b0;
			end
			if (lock_q && ext_edge) begin
				ph_q <= '0;
			end else begin
				ph_q <= ph_wrap ? '0 : ph_q + 1'b1;
			end
			sw_clk_o <= ph_q < (osc_per >> 1);
		end
	end

	// Register read mux.
	wire [31:0] stat_w = {8'h00, ext_period, 3'h0, ext_present, hold_q,
		lock_q, pg_q, ready_st, 1'b0, ref_q == ssq_pkg::RAMP_FULL, st_q};
	wire [31:0] strap_w = {eff_ramp, eff_dly};
	wire [31:0] rd_w = hit_ctrl ? (ctrl_q & ~32'h0000_0001)
		: hit_dly ? dly_q : hit_ramp ? ramp_q : hit_pgd ? pgd_q
		: hit_win ? win_q : hit_stat ? stat_w : hit_strap ? strap_w
		: 32'h0000_0000;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q    <= ssq_pkg::CTRL_RST;
			dly_q     <= ssq_pkg::TIME_RST;
			ramp_q    <= ssq_pkg::TIME_RST;
			pgd_q     <= ssq_pkg::TIME_RST;
			win_q     <= ssq_pkg::PGWIN_RST;
			ack_q     <= 1'b0;
			restore_q <= 1'b0;
		end else begin
			ack_q     <= wb_act & ~ack_q;
			restore_q <= wb_wr & hit_ctrl & wdat[ssq_pkg::CTRL_RESTORE];
			if (wb_wr && hit_ctrl) begin
				ctrl_q <= (ctrl_q & ~wmask) | wdat;
			end
			if (wb_wr && hit_dly) begin
				dly_q <= (dly_q & ~wmask) | wdat;
			end
			if (wb_wr && hit_ramp) begin
				ramp_q <= (ramp_q & ~wmask) | wdat;
			end
			if (wb_wr && hit_pgd) begin
				pgd_q <= (pgd_q & ~wmask) | wdat;
			end
			if (wb_wr && hit_win) begin
				win_q <= (win_q & ~wmask) | wdat;
			end
		end
	end

	// Registered pin and bus outputs.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_rsp_o      <= '0;
			sync_o        <= 1'b0;
			sync_oe_n_o   <= 1'b1;
			ramp_ref_o    <= '0;
			output_good_o <= 1'b0;
			dev_ready_o   <= 1'b0;
		end else begin
			wb_rsp_o.ack  <= wb_act & ~ack_q;
			wb_rsp_o.dat  <= rd_w;
			sync_o        <= ph_q < (osc_per >> 1);
			sync_oe_n_o   <= !(mode_out && ready_st);
			ramp_ref_o    <= ref_q;
			output_good_o <= pg_q ~^ ctrl_q[ssq_pkg::CTRL_PG_POL];
			dev_ready_o   <= ready_st;
		end
	end

endmodule : ssq_top

// *** tb/ssq_chk.sv ***
// Port checker for the start-up sequencer.
`timescale 1ns/100ps
module ssq_chk #(
	parameter int US_PER_MS  = 1000,
	parameter int INIT_MS    = 5,
	parameter int MIN_DLY_MS = 2
) (
	// Clock and reset.
	input wire logic                 clk_i,
	input wire logic                 rst_i,
	// Bus and pins.
	input wire ssq_pkg::ssq_wb_req_t wb_req_i,
	input wire ssq_pkg::ssq_wb_rsp_t wb_rsp_o,
	input wire logic                 enable_i,
	input wire logic                 fault_i,
	input wire logic                 sync_o,
	input wire logic                 sync_oe_n_o,
	input wire logic [9:0]           ramp_ref_o,
	input wire logic                 output_good_o,
	input wire logic                 dev_ready_o
);
	localparam int DLY_CYC = MIN_DLY_MS * US_PER_MS * ssq_pkg::US_CYC;
	logic [15:0] en_q;
	logic [15:0] per_q;
	logic        pol_q;
	logic        sync_q;
	logic        seen_q;
	wire         rise = sync_o && !sync_q;
	wire         ctl_wr = wb_rsp_o.ack && wb_req_i.we && wb_req_i.sel[0]
		&& wb_req_i.adr == ssq_pkg::REG_CTRL;
	wire         en_clr = rst_i || (!enable_i && ramp_ref_o == 10'h0);
	// Cycles since enable, period of the driven clock and pin polarity.
	always_ff @(posedge clk_i) begin
		en_q <= en_clr ? 16'h0 : en_q + {15'h0, en_q != 16'hFFFF};
		per_q <= rise ? 16'h1 : per_q + 16'h1;
		sync_q <= sync_o;
		seen_q <= !sync_oe_n_o && (seen_q || rise);
		pol_q <= rst_i ? 1'b1 : ctl_wr ? wb_req_i.dat[4] : pol_q;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence fault_held;
		fault_i [*4];
	endsequence
	wb_ack_a: assert property (
		wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=> wb_rsp_o.ack)
		else $error("bus request not acknowledged");
	ack_pulse_a: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
		else $error("acknowledge longer than one cycle");
	unmapped_read_a: assert property (
		wb_rsp_o.ack && !wb_req_i.we && wb_req_i.adr > ssq_pkg::REG_STRAP
		|-> wb_rsp_o.dat == 32'h0) else $error("unmapped read not zero");
	init_wait_a: assert property ($fell(rst_i) |-> !dev_ready_o [*8])
		else $error("ready too early after reset");
	ramp_hold_a: assert property (
		ramp_ref_o != 10'h0 |-> en_q >= DLY_CYC)
		else $error("ramp started before minimum delay");
	pg_fault_a: assert property (
		fault_held |-> output_good_o != pol_q)
		else $error("output good active during fault");
	pg_after_ramp_a: assert property (
		output_good_o == pol_q && $past(output_good_o) != pol_q
		|-> ramp_ref_o == ssq_pkg::RAMP_FULL)
		else $error("output good before ramp complete");
	sync_period_a: assert property (
		rise && seen_q && !sync_oe_n_o |-> per_q == 16'h1F4)
		else $error("driven clock period wrong");
endmodule : ssq_chk

bind ssq_top ssq_chk #(
	.US_PER_MS(US_PER_MS), .INIT_MS(INIT_MS), .MIN_DLY_MS(MIN_DLY_MS)
) chk_u (
	.clk_i, .rst_i, .wb_req_i, .wb_rsp_o, .enable_i, .fault_i, .sync_o,
	.sync_oe_n_o, .ramp_ref_o, .output_good_o, .dev_ready_o
);

// *** tb/ssq_clk_src.sv ***
// External clock source on the shared clock pin.
`timescale 1ns/100ps
module ssq_clk_src #(
	parameter int PER_NS = 2000
) (
	// Control.
	input  wire logic run_i,
	input  wire logic drv_i,
	// Pin drive.
	output logic      clk_o,
	output logic      oe_n_o
);
	// A stopped source holds its line low.
	initial begin
		clk_o = 1'b0;
		#1.3;
		forever begin
			#(PER_NS / 2.0);
			clk_o = run_i ? !clk_o : 1'b0;
		end
	end
	assign oe_n_o = !drv_i;
endmodule : ssq_clk_src

// *** tb/tb_ssq_top.sv ***
// Self-checking bench for the start-up sequencer.
`timescale 1ns/100ps
module tb_ssq_top;
	localparam int MS = 2 * ssq_pkg::US_CYC;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	ssq_pkg::ssq_wb_req_t req = '0;
	ssq_pkg::ssq_wb_rsp_t rsp;
	ssq_pkg::ssq_cmp_t [4:0] cmp = '0;
	logic [1:0] rv = 2'h0;
	logic [1:0][4:0] rc = '0;
	logic en = 1'b0;
	logic [7:0] verr = 8'h00;
	logic flt = 1'b0;
	logic run = 1'b0;
	logic drv = 1'b0;
	logic pull = 1'b0;
	logic ck, ck_oe_n, so, so_oe_n, swc, pg, rdy, sync_w;
	logic [9:0] rr;
	logic [31:0] rd;
	int err_count = 0;
	int check_count = 0;
	int cyc = 0;
	always #2.5 clk_i = !clk_i;
	assign sync_w = !so_oe_n ? so : !ck_oe_n ? ck : pull;
	ssq_top #(.US_PER_MS(2), .INIT_MS(1), .MIN_DLY_MS(2)) DUT (
		.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
		.strap_cmp_i(cmp), .strap_res_valid_i(rv), .strap_res_code_i(rc),
		.enable_i(en), .vout_err_i(verr), .fault_i(flt), .sync_i(sync_w),
		.sync_o(so), .sync_oe_n_o(so_oe_n), .ramp_ref_o(rr),
		.output_good_o(pg), .sw_clk_o(swc), .dev_ready_o(rdy));
	ssq_clk_src #(.PER_NS(2000)) src (
		.run_i(run), .drv_i(drv), .clk_o(ck), .oe_n_o(ck_oe_n));
	task automatic chk(input string n, input logic [31:0] e, g);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic near(input string n, input int e, g, t);
		chk(n, 32'(e), (g >= e - t && g <= e + t) ? 32'(e) : 32'(g));
	endtask : near
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
		do @(posedge clk_i); while (rsp.ack !== 1'b1);
		rd = rsp.dat;
		req <= '0;
	endtask : wb
	task automatic restore(input logic [31:0] c);
		wb(1'b1, ssq_pkg::REG_CTRL, c | 32'h1);
		repeat (4) @(posedge clk_i);
		while (rdy !== 1'b1) @(posedge clk_i);
	endtask : restore
	task automatic per(input bit s, input int e, input string n);
		realtime t;
		repeat (2) begin
			t = $realtime;
			if (s) @(posedge so); else @(posedge swc);
		end
		near(n, e, $rtoi($realtime - t), 10);
	endtask : per
	function automatic ssq_pkg::ssq_cmp_t lv(input int l);
		return l == 0 ? 2'h1 : l == 1 ? 2'h0 : 2'h2;
	endfunction : lv
	task automatic t_regs;
		wb(1'b0, ssq_pkg::REG_CTRL, 32'h0);
		chk("ctrl", 32'h10, rd);
		wb(1'b0, ssq_pkg::REG_PGWIN, 32'h0);
		chk("pgwin", 32'hF0A, rd);
		wb(1'b1, 8'h40, 32'hFFFF_FFFF);
		wb(1'b0, 8'h40, 32'h0);
		chk("unmapped", 32'h0, rd);
		$display("test regs done");
	endtask : t_regs
	task automatic t_straps;
		logic [31:0] e [4] = '{32'h2, 32'h5_000A, 32'hA_00C8, 32'h5_0002};
		int l [4][3] = '{'{0, 0, 0}, '{1, 1, 1}, '{2, 2, 2}, '{1, 1, 0}};
		for (int i = 0; i < 4; i++) begin
			cmp[0] <= lv(l[i][0]);
			cmp[1] <= lv(l[i][1]);
			cmp[2] <= lv(l[i][2]);
			restore(32'h10);
			wb(1'b0, ssq_pkg::REG_STRAP, 32'h0);
			chk("strap", e[i], rd);
		end
		cmp[0] <= lv(2);
		wb(1'b0, ssq_pkg::REG_STRAP, 32'h0);
		chk("strap_held", 32'h5_0002, rd);
		rv <= 2'h3;
		rc <= {5'h03, 5'h07};
		restore(32'h10);
		wb(1'b0, ssq_pkg::REG_STRAP, 32'h0);
		chk("res", 32'h46_001E, rd);
		rc <= {5'h14, 5'h14};
		wb(1'b0, ssq_pkg::REG_STRAP, 32'h0);
		chk("res_held", 32'h46_001E, rd);
		restore(32'h10);
		wb(1'b0, ssq_pkg::REG_STRAP, 32'h0);
		chk("res_max", 32'hC8_00C8, rd);
		rv <= 2'h0;
		$display("test straps done");
	endtask : t_straps
	task automatic t_seq;
		int n;
		verr <= 8'hF6;
		wb(1'b1, ssq_pkg::REG_DLY, 32'h0);
		wb(1'b1, ssq_pkg::REG_RAMP, 32'h3);
		wb(1'b1, ssq_pkg::REG_CTRL, 32'h16);
		en <= 1'b1;
		for (n = 0; rr === 10'h0; n++) @(posedge clk_i);
		near("delay", 2 * MS, n, 8);
		for (n = 0; rr !== 10'h3FF; n++) @(posedge clk_i);
		near("ramp", 3 * MS, n, 8);
		for (n = 0; pg !== 1'b1 && n < 5 * MS; n++) @(posedge clk_i);
		near("pg_delay", 7 * MS / 2, n, MS / 2 + 8);
		verr <= 8'hF5;
		repeat (4) @(posedge clk_i);
		chk("pg_low", 32'h0, 32'(pg));
		verr <= 8'h0F;
		repeat (4 * MS) @(posedge clk_i);
		chk("pg_high", 32'h1, 32'(pg));
		flt <= 1'b1;
		repeat (4) @(posedge clk_i);
		chk("pg_fault", 32'h0, 32'(pg));
		flt <= 1'b0;
		wb(1'b1, ssq_pkg::REG_CTRL, 32'h6);
		repeat (3) @(posedge clk_i);
		chk("pg_pol_idle", 32'h1, 32'(pg));
		repeat (4 * MS) @(posedge clk_i);
		chk("pg_pol_on", 32'h0, 32'(pg));
		en <= 1'b0;
		while (rr !== 10'h0) @(posedge clk_i);
		wb(1'b1, ssq_pkg::REG_RAMP, 32'h0);
		en <= 1'b1;
		for (n = 0; rr !== 10'h3FF; n++) @(posedge clk_i);
		near("ramp_zero", 2 * MS, n, 8);
		wb(1'b1, ssq_pkg::REG_CTRL, 32'h10);
		en <= 1'b0;
		$display("test sequence done");
	endtask : t_seq
	task automatic t_clk;
		int f [3] = '{5000, 2500, 1000};
		cmp[3] <= lv(2);
		restore(32'h10);
		chk("oe_n", 32'h0, 32'(so_oe_n));
		per(1'b1, 2500, "sync_out");
		per(1'b0, 2500, "sw_out");
		for (int m = 0; m < 2; m++) begin
			cmp[3] <= lv(m);
			drv <= 1'b1;
			run <= 1'b1;
			restore(32'h10);
			repeat (2 * MS) @(posedge clk_i);
			en <= 1'b1;
			repeat (3 * MS) @(posedge clk_i);
			wb(1'b0, ssq_pkg::REG_STATUS, 32'h0);
			chk("locked", 32'h1, 32'(rd[7]));
			per(1'b0, 2000, "sw_locked");
			run <= 1'b0;
			repeat (2600) @(posedge clk_i);
			wb(1'b0, ssq_pkg::REG_STATUS, 32'h0);
			chk("holdover", 32'h1, 32'(rd[8]));
			per(1'b0, 2000, "sw_hold");
			en <= 1'b0;
		end
		drv <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			cmp[4] <= lv(i);
			pull <= (i == 2);
			restore(32'h10);
			en <= 1'b1;
			repeat (10) @(posedge clk_i);
			per(1'b0, f[i], "sw_auto");
			en <= 1'b0;
		end
		$display("test clock done");
	endtask : t_clk
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 60000) begin
			err_count++;
			tally_and_finish;
		end
	end
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		while (rdy !== 1'b1) @(posedge clk_i);
		t_regs;
		t_straps;
		t_seq;
		t_clk;
		tally_and_finish;
	end
endmodule : tb_ssq_top
